// *** pkg/cxp_pkg.sv ***
package cxp_pkg;
  // word layout
  localparam int FRAME_W = 6;
  localparam int ADDR_W = 6;
  localparam int FIELD_W = 3;
  localparam int NUM_OUT = 4;
  localparam int CFG_W = 12;
  localparam int WORD_BITS = 30;
  localparam int PIPE_STAGES = 7;
  localparam int CNT_W = 5;
  // start frames
  localparam logic [5:0] FRAME_WRITE = 6'h1f;
  localparam logic [5:0] FRAME_READ = 6'h1e;
  // bit counts within a word: CNT_FRAME loaded on the frame edge, the others held just before the named edge
  localparam logic [4:0] CNT_FRAME = 5'h06;
  localparam logic [4:0] CNT_ROW_DONE = 5'h0b;
  localparam logic [4:0] CNT_COL_DONE = 5'h11;
  localparam logic [4:0] CNT_LAST = 5'h1d;
  localparam logic [3:0] HUNT_SETTLED = 4'h8;
  // reset values
  localparam logic [11:0] CFG_RESET = 12'h000;

  typedef enum logic [1:0] {LINK_HUNT = 2'b01, LINK_WORD = 2'b10} cxp_link_state_type;

  // address step, wraps modulo 64
  function automatic logic [5:0] cxp_dec_addr(input logic [5:0] a);
    return a - 6'h01;
  endfunction

  // selection code 1..4 picks an input
  function automatic logic cxp_sel_ok(input logic [2:0] sel);
    return (sel >= 3'h1) && (sel <= 3'h4);
  endfunction

  function automatic logic cxp_route(input logic [2:0] sel, input logic [3:0] ins);
    logic [2:0] idx;
    idx = sel - 3'h1;
    if (cxp_sel_ok(sel))
    begin
      return ins[idx[1:0]];
    end
    return 1'b0;
  endfunction
endpackage

// *** pkg/cxp_pipe_if.sv ***
`timescale 1ns/100ps
// one forwarding pipe: controller feeds bits and address overrides
interface cxp_pipe_if;
  logic shift_in;
  logic load_en;
  logic [5:0] load_val;
  logic ser_out;
  modport ctrl (output shift_in, output load_en, output load_val, input ser_out);
  modport pipe (input shift_in, input load_en, input load_val, output ser_out);
endinterface

// *** core/cxp_sync.sv ***
`timescale 1ns/100ps
// two flip-flop synchroniser, no reset
module cxp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule // cxp_sync

// *** core/cxp_fwd_pipe.sv ***
`timescale 1ns/100ps
// forwarding shift pipe with in-place address override
module cxp_fwd_pipe import cxp_pkg::*; #(
  parameter int STAGES = PIPE_STAGES
) (
  input wire logic serial_clock,
  input wire logic link_rstn,
  cxp_pipe_if.pipe pif
);
  logic [STAGES-1:0] stage_r;

  // newest bit in stage 0, the last stage drives the output
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      stage_r <= '0;
    end
    else if (pif.load_en)
    begin
      stage_r <= {stage_r[STAGES-2:ADDR_W-1], pif.load_val};
    end
    else
    begin
      stage_r <= {stage_r[STAGES-2:0], pif.shift_in};
    end
  end

  assign pif.ser_out = stage_r[STAGES-1];
endmodule // cxp_fwd_pipe

// *** core/cxp_crosspoint_cfg.sv ***
`timescale 1ns/100ps
module cxp_crosspoint_cfg import cxp_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic input_port_one,
  input wire logic input_port_two,
  input wire logic input_port_three,
  input wire logic input_port_four,
  output logic output_port_one,
  output logic output_port_two,
  output logic output_port_three,
  output logic output_port_four,
  output logic output_port_one_oe,
  output logic output_port_two_oe,
  output logic output_port_three_oe,
  output logic output_port_four_oe,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic first_column,
  output logic row_serial_out,
  output logic row_serial_clock_out,
  output logic col_serial_out,
  output logic col_serial_clock_out
);
  // crossing flops and their views
  logic [5:0] core_sync;
  logic [2:0] link_sync;
  logic link_rstn;
  logic cfg_tgl_l;
  logic fcol;
  logic [3:0] in_s;
  logic load_s;
  logic ld_tgl_c;
  // link side state
  cxp_link_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [FRAME_W-2:0] win_r;
  logic [5:0] field_now;
  logic frame_wr;
  logic frame_rd;
  logic is_read_r;
  logic row_zero_r;
  logic hit;
  logic ins_r;
  logic cap_r;
  logic [CFG_W-1:0] cfg_sr;
  logic [CFG_W-2:0] data_sr;
  logic [CFG_W-1:0] load_r;
  logic ld_tgl_r;
  logic cfg_seen_r;
  logic [CFG_W-1:0] cfg_sl;
  logic [3:0] hunt_run_r;
  // core side state
  logic ld_seen_r;
  logic [CFG_W-1:0] pend_r;
  logic [CFG_W-1:0] cfg_r;
  logic cfg_tgl_r;
  logic [NUM_OUT-1:0] out_r;
  logic [NUM_OUT-1:0] oe_r;

  cxp_pipe_if rp_if ();
  cxp_pipe_if cp_if ();

  // link side synchronisers: reset, config toggle, column strap
  cxp_sync #(.W(3)) u_link_sync (
    .clk(serial_clock),
    .d({rstn, cfg_tgl_r, first_column}),
    .q(link_sync)
  );

  assign link_rstn = link_sync[2];
  assign cfg_tgl_l = link_sync[1];
  assign fcol = link_sync[0];

  // core side synchronisers: inputs, load pin, capture toggle
  cxp_sync #(.W(6)) u_core_sync (
    .clk(core_clk),
    .d({input_port_four, input_port_three, input_port_two, input_port_one, load, ld_tgl_r}),
    .q(core_sync)
  );

  assign in_s = core_sync[5:2];
  assign load_s = core_sync[1];
  assign ld_tgl_c = core_sync[0];

  // newest six bits, frame comparison
  assign field_now = {win_r, serial_in};
  assign frame_wr = (state_r == LINK_HUNT) && (field_now == FRAME_WRITE);
  assign frame_rd = (state_r == LINK_HUNT) && (field_now == FRAME_READ);
  assign hit = (state_r == LINK_WORD) && (cnt_r == CNT_COL_DONE) && row_zero_r
               && (field_now == 6'h00);

  // word tracking state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LINK_HUNT:
      begin
        if (frame_wr || frame_rd)
        begin
          state_nxt = LINK_WORD;
        end
        else
        begin
          state_nxt = LINK_HUNT;
        end
      end
      LINK_WORD:
      begin
        if (cnt_r == CNT_LAST)
        begin
          state_nxt = LINK_HUNT;
        end
      end
      default:
      begin
        state_nxt = LINK_HUNT;
      end
    endcase
  end

  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      state_r <= LINK_HUNT;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // bit counter and frame kind
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      cnt_r <= '0;
      is_read_r <= 1'b0;
    end
    else if (frame_wr || frame_rd)
    begin
      cnt_r <= CNT_FRAME;
      is_read_r <= frame_rd;
    end
    else if (state_r == LINK_WORD)
    begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // raw window of the latest bits
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      win_r <= '0;
    end
    else
    begin
      win_r <= field_now[FRAME_W-2:0];
    end
  end

  // row address zero check, remembered until the column is in
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      row_zero_r <= 1'b0;
    end
    else if ((state_r == LINK_WORD) && (cnt_r == CNT_ROW_DONE))
    begin
      row_zero_r <= (field_now == 6'h00);
    end
  end

  // read insertion of the current configuration
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      ins_r <= 1'b0;
      cfg_sr <= CFG_RESET;
    end
    else if (hit && is_read_r)
    begin
      ins_r <= 1'b1;
      cfg_sr <= cfg_sl;
    end
    else if (ins_r)
    begin
      ins_r <= (cnt_r != CNT_LAST);
      cfg_sr <= {cfg_sr[CFG_W-2:0], 1'b0};
    end
  end

  // write capture into the load register
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      cap_r <= 1'b0;
      data_sr <= '0;
      load_r <= CFG_RESET;
      ld_tgl_r <= 1'b0;
    end
    else
    begin
      data_sr <= {data_sr[CFG_W-3:0], serial_in};
      if (hit && !is_read_r)
      begin
        cap_r <= 1'b1;
      end
      else if (cap_r && (cnt_r == CNT_LAST))
      begin
        cap_r <= 1'b0;
        load_r <= {data_sr, serial_in};
        ld_tgl_r <= ~ld_tgl_r;
      end
    end
  end

  // configuration copy brought over for read-back
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn)
    begin
      cfg_seen_r <= 1'b0;
      cfg_sl <= CFG_RESET;
    end
    else
    begin
      cfg_seen_r <= cfg_tgl_l;
      if (cfg_tgl_l != cfg_seen_r)
      begin
        cfg_sl <= cfg_r;
      end
    end
  end

  // forwarding pipes, row address stepped on row, column on column
  assign rp_if.shift_in = ins_r ? cfg_sr[CFG_W-1] : serial_in;
  assign rp_if.load_en = (state_r == LINK_WORD) && (cnt_r == CNT_ROW_DONE);
  assign rp_if.load_val = cxp_dec_addr(field_now);
  assign cp_if.shift_in = ins_r ? cfg_sr[CFG_W-1] : serial_in;
  assign cp_if.load_en = (state_r == LINK_WORD) && (cnt_r == CNT_COL_DONE);
  assign cp_if.load_val = cxp_dec_addr(field_now);

  cxp_fwd_pipe u_row_pipe (
    .serial_clock(serial_clock),
    .link_rstn(link_rstn),
    .pif(rp_if.pipe)
  );

  cxp_fwd_pipe u_col_pipe (
    .serial_clock(serial_clock),
    .link_rstn(link_rstn),
    .pif(cp_if.pipe)
  );

  // serial outputs; clock forwarded as is, column clock only in first column
  assign row_serial_out = rp_if.ser_out;
  assign row_serial_clock_out = serial_clock;
  assign col_serial_out = cp_if.ser_out;
  assign col_serial_clock_out = serial_clock & fcol;

  // pending word taken over when the capture toggle moves
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ld_seen_r <= 1'b0;
      pend_r <= CFG_RESET;
    end
    else
    begin
      ld_seen_r <= ld_tgl_c;
      if (ld_tgl_c != ld_seen_r)
      begin
        pend_r <= load_r;
      end
    end
  end

  // shared load applies the pending word
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cfg_r <= CFG_RESET;
      cfg_tgl_r <= 1'b0;
    end
    else if (load_s)
    begin
      cfg_r <= pend_r;
      if (cfg_r != pend_r)
      begin
        cfg_tgl_r <= ~cfg_tgl_r;
      end
    end
  end

  // output multiplexers, invalid codes held off
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      out_r <= '0;
      oe_r <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        out_r[i] <= cxp_route(cfg_r[CFG_W-1-FIELD_W*i -: FIELD_W], in_s);
        oe_r[i] <= cxp_sel_ok(cfg_r[CFG_W-1-FIELD_W*i -: FIELD_W]);
      end
    end
  end

  assign output_port_one = out_r[0];
  assign output_port_two = out_r[1];
  assign output_port_three = out_r[2];
  assign output_port_four = out_r[3];
  assign output_port_one_oe = oe_r[0];
  assign output_port_two_oe = oe_r[1];
  assign output_port_three_oe = oe_r[2];
  assign output_port_four_oe = oe_r[3];

  // cycles spent hunting, for the pass-through check
  always_ff @(posedge serial_clock)
  begin
    if (!link_rstn || (state_r != LINK_HUNT))
    begin
      hunt_run_r <= 4'h0;
    end
    else if (hunt_run_r != HUNT_SETTLED)
    begin
      hunt_run_r <= hunt_run_r + 4'h1;
    end
  end

  a_frame_write_seen: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    frame_wr |=> (state_r == LINK_WORD) && (cnt_r == CNT_FRAME) && !is_read_r)
    else $error("write frame not taken");

  a_bad_frame_ignored: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    (state_r == LINK_HUNT) && !frame_wr && !frame_rd |=> (state_r == LINK_HUNT) && !cap_r)
    else $error("unframed bits started a word");

  a_pass_latency: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    (hunt_run_r == HUNT_SETTLED) |-> (row_serial_out == $past(serial_in, 7))
      && (col_serial_out == $past(serial_in, 7)))
    else $error("forward latency is not seven edges");

  a_row_addr_step: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    rp_if.load_en |-> ##7 ({$past(row_serial_out, 5), $past(row_serial_out, 4),
      $past(row_serial_out, 3), $past(row_serial_out, 2), $past(row_serial_out, 1),
      row_serial_out} == $past(field_now, 7) - 6'h01))
    else $error("row address not decremented on row output");

  a_col_addr_step: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    cp_if.load_en |-> ##7 ({$past(col_serial_out, 5), $past(col_serial_out, 4),
      $past(col_serial_out, 3), $past(col_serial_out, 2), $past(col_serial_out, 1),
      col_serial_out} == $past(field_now, 7) - 6'h01))
    else $error("column address not decremented on column output");

  a_read_fields_out: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    hit && is_read_r |-> ##10 ({$past(row_serial_out, 2), $past(row_serial_out, 1),
      row_serial_out} == $past(cfg_sl[11:9], 10)))
    else $error("read-back fields not inserted");

  a_write_capture: assert property (@(posedge serial_clock) disable iff (!link_rstn)
    cap_r && (cnt_r == CNT_LAST) |=> (ld_tgl_r != $past(ld_tgl_r))
      && (load_r[0] == $past(serial_in)) && (load_r[11:1] == $past(data_sr)))
    else $error("addressed write not captured");

  a_cfg_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !load_s |=> $stable(cfg_r))
    else $error("configuration changed without load");

  a_load_apply: assert property (@(posedge core_clk) disable iff (!rstn)
    load_s |=> (cfg_r == $past(pend_r)))
    else $error("load did not apply pending word");

  a_route_input_two: assert property (@(posedge core_clk) disable iff (!rstn)
    (cfg_r[11:9] == 3'h2) && (cfg_r[8:6] == 3'h2) |=> output_port_one_oe && output_port_two_oe
      && (output_port_one == $past(in_s[1])) && (output_port_two == $past(in_s[1])))
    else $error("input two not routed");

  a_tristate_code: assert property (@(posedge core_clk) disable iff (!rstn)
    (cfg_r[2:0] == 3'h0) || (cfg_r[2:0] > 3'h4) |=> !output_port_four_oe)
    else $error("output driven with off code");
endmodule // cxp_crosspoint_cfg

// *** verif/cxp_host_model.sv ***
`timescale 1ns/100ps
// host controller: burst serial clock, data changed while the clock is low
module cxp_host_model (
  output logic serial_clock,
  output logic serial_in,
  input wire logic row_serial_out,
  input wire logic row_serial_clock_out,
  input wire logic col_serial_out,
  input wire logic col_serial_clock_out
);
  logic [59:0] row_rx_r;
  logic [59:0] col_rx_r;
  int col_edges;
  int row_edges;

  // clock stands low between bursts, data line backfilled with zeros
  initial
  begin
    serial_clock = 1'b0;
    serial_in = 1'b0;
    col_edges = 0;
    row_edges = 0;
    row_rx_r = '0;
    col_rx_r = '0;
  end

  // capture forwarded bits on the edge a downstream device would use
  always @(posedge serial_clock)
  begin
    row_rx_r <= {row_rx_r[58:0], row_serial_out};
    col_rx_r <= {col_rx_r[58:0], col_serial_out};
  end

  // count forwarded column clock edges
  always @(posedge col_serial_clock_out)
    col_edges <= col_edges + 1;

  // count forwarded row clock edges
  always @(posedge row_serial_clock_out)
    row_edges <= row_edges + 1;

  // one serial clock period of 80 ns with one data bit
  task automatic pulse(input logic d);
    serial_in = d;
    #40 serial_clock = 1'b1;
    #40 serial_clock = 1'b0;
  endtask

  // zero bits with the clock running
  task automatic idle(input int n);
    repeat (n) pulse(1'b0);
  endtask

  // words sent first bit first, furthest device first; then trailing clocks
  task automatic send(input logic [59:0] b, input int n);
    int i;
    for (i = n - 1; i >= 0; i--)
      pulse(b[i]);
    idle(7);
  endtask
endmodule // cxp_host_model

// *** verif/cxp_crosspoint_cfg_tb.sv ***
`timescale 1ns/100ps
// bench for the cross-point serial configuration block
module cxp_crosspoint_cfg_tb;
  import cxp_pkg::*;
  logic core_clk;
  logic rstn;
  logic load;
  logic first_column;
  logic [3:0] ins;
  logic [3:0] outs;
  logic [3:0] oes;
  logic serial_clock;
  logic serial_in;
  logic row_serial_out;
  logic row_serial_clock_out;
  logic col_serial_out;
  logic col_serial_clock_out;
  logic [11:0] exp_cfg;
  logic [11:0] exp_pend;
  logic [11:0] cases [0:6];
  int mismatches;
  int checks;
  int k;

  cxp_crosspoint_cfg i_cxp_crosspoint_cfg (
    .core_clk(core_clk), .rstn(rstn), .load(load),
    .input_port_one(ins[0]), .input_port_two(ins[1]),
    .input_port_three(ins[2]), .input_port_four(ins[3]),
    .output_port_one(outs[3]), .output_port_two(outs[2]),
    .output_port_three(outs[1]), .output_port_four(outs[0]),
    .output_port_one_oe(oes[3]), .output_port_two_oe(oes[2]),
    .output_port_three_oe(oes[1]), .output_port_four_oe(oes[0]),
    .serial_clock(serial_clock), .serial_in(serial_in), .first_column(first_column),
    .row_serial_out(row_serial_out), .row_serial_clock_out(row_serial_clock_out),
    .col_serial_out(col_serial_out), .col_serial_clock_out(col_serial_clock_out)
  );

  cxp_host_model i_cxp_host_model (
    .serial_clock(serial_clock), .serial_in(serial_in),
    .row_serial_out(row_serial_out), .row_serial_clock_out(row_serial_clock_out),
    .col_serial_out(col_serial_out), .col_serial_clock_out(col_serial_clock_out)
  );

  // core clock, 100 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // forwarded word: valid frames step the address of the output used
  function automatic logic [29:0] exp_fwd(input logic [29:0] w, input bit on_row,
                                          input logic [11:0] cur);
    logic [5:0] r;
    logic [5:0] c;
    logic [11:0] f;
    if ((w[29:24] != 6'h1f) && (w[29:24] != 6'h1e))
      return w;
    r = w[23:18];
    c = w[17:12];
    f = w[11:0];
    if ((w[29:24] == 6'h1e) && (r == 6'h00) && (c == 6'h00))
      f = cur;
    if (on_row)
      r = r - 6'h01;
    else
      c = c - 6'h01;
    return {w[29:24], r, c, f};
  endfunction

  // enables and routed values for a configuration
  function automatic logic [7:0] exp_outs(input logic [11:0] c, input logic [3:0] x);
    logic [2:0] s;
    logic [3:0] oe;
    logic [3:0] v;
    for (int i = 0; i < 4; i++)
    begin
      s = c[11 - 3 * i -: 3];
      oe[3 - i] = (s >= 3'h1) && (s <= 3'h4);
      v[3 - i] = oe[3 - i] ? x[s - 3'h1] : 1'b0;
    end
    return {oe, v};
  endfunction

  task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // send one or two words, compare both forwarded streams, track pending
  task automatic xfer(input logic [59:0] b, input int n);
    int c0;
    int r0;
    logic [29:0] w;
    c0 = i_cxp_host_model.col_edges;
    r0 = i_cxp_host_model.row_edges;
    i_cxp_host_model.send(b, n);
    for (int j = n / 30 - 1; j >= 0; j--)
    begin
      w = b[30 * j +: 30];
      chk("row word", exp_fwd(w, 1'b1, exp_cfg), i_cxp_host_model.row_rx_r[30 * j +: 30]);
      chk("col word", exp_fwd(w, 1'b0, exp_cfg), i_cxp_host_model.col_rx_r[30 * j +: 30]);
      if ((w[29:24] == 6'h1f) && (w[23:12] == 12'h000))
        exp_pend = w[11:0];
    end
    chk("col clocks", 30'(first_column ? n + 7 : 0), 30'(i_cxp_host_model.col_edges - c0));
    chk("row clocks", 30'(n + 7), 30'(i_cxp_host_model.row_edges - r0));
  endtask

  // random input patterns against the expected routing
  task automatic check_outs();
    logic [7:0] e;
    repeat (3)
    begin
      @(negedge core_clk);
      ins = 4'($urandom);
      repeat (5) @(negedge core_clk);
      e = exp_outs(exp_cfg, ins);
      chk("enables", 30'(e[7:4]), 30'(oes));
      chk("outputs", 30'(e[3:0]), 30'(outs & e[7:4]));
    end
  endtask

  // shared load pulse after the trailing clocks
  task automatic do_load();
    repeat (5) @(negedge core_clk);
    load = 1'b1;
    repeat (4) @(negedge core_clk);
    load = 1'b0;
    repeat (6) @(negedge core_clk);
    exp_cfg = exp_pend;
    check_outs();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if ((mismatches == 0) && (checks > 0))
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog well past the expected run length
  initial
  begin
    #600000;
    mismatches++;
    summarize();
  end

  initial
  begin
    mismatches = 0;
    checks = 0;
    rstn = 1'b0;
    load = 1'b0;
    first_column = 1'b1;
    ins = 4'h0;
    exp_cfg = CFG_RESET;
    exp_pend = CFG_RESET;
    void'($urandom(32'h3b95e4e2));
    i_cxp_host_model.idle(6);
    chk("reset oe", 30'h0, 30'(oes));
    @(negedge core_clk);
    rstn = 1'b1;
    i_cxp_host_model.idle(8);
    cases[0] = 12'h4a4;
    cases[1] = 12'h249;
    cases[2] = 12'h040;
    cases[3] = 12'h29c;
    for (k = 4; k < 7; k++)
      cases[k] = {3'($urandom_range(4, 0)), 3'($urandom_range(4, 1)),
                  3'($urandom_range(4, 0)), 3'($urandom_range(4, 1))};
    // addressed write, no change before load, then load and read back
    for (k = 0; k < 7; k++)
    begin
      xfer({30'h0, 6'h1f, 12'h000, cases[k]}, 30);
      check_outs();
      do_load();
      xfer({30'h0, 6'h1e, 12'h000, 12'h000}, 30);
    end
    // back to back writes: next row first, own word last
    xfer({6'h1f, 6'h01, 6'h00, 12'h249, 6'h1f, 12'h000, 12'h4a4}, 60);
    check_outs();
    do_load();
    // back to back reads of next row and of this device
    xfer({6'h1e, 6'h01, 6'h00, 12'h000, 6'h1e, 12'h000, 12'h000}, 60);
    // near-miss frames pass through untouched and store nothing
    xfer({6'h15, 12'h000, 12'h249, 6'h1d, 12'h000, 12'h249}, 60);
    do_load();
    // column clock gated off by the strap
    @(negedge core_clk);
    first_column = 1'b0;
    i_cxp_host_model.idle(4);
    xfer({30'h0, 6'h1f, 6'h02, 6'h03, 12'h29c}, 30);
    summarize();
  end
endmodule // cxp_crosspoint_cfg_tb
